//--- lsa_top.sv
`timescale 1ns/1ps
module lsa_top import lsa_pkg::*; #(
  parameter int SAMPLE_CYCLES = SAMPLE_CYC,
  parameter int REFRESH_CYCLES = REFRESH_CYC,
  parameter logic [7:0] ID_PART = ID_PART_DEF,
  parameter logic [7:0] ID_MFR = ID_MFR_DEF
) (
  input wire logic i_clk_sys,
  input wire logic i_srst,
  input wire logic i_ce,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_out,
  output logic o_sda_oe,
  output logic o_conv_start,
  input wire lsa_conv_t i_conv,
  output logic [15:0] o_result,
  output logic o_active
);
  // Pin synchronisers, {sda, scl}; stage 1 feeds only stage 2, stage 3 only marks edges
  logic [1:0] pin_s1_r, pin_s2_r, pin_s3_r;
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      pin_s1_r <= 2'h3;
      pin_s2_r <= 2'h3;
      pin_s3_r <= 2'h3;
    end else if (i_ce) begin
      pin_s1_r <= {i_sda, i_scl};
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
    end
  end
  logic scl_rise, scl_fall, bus_start, bus_stop;
  assign scl_rise = pin_s2_r[0] & ~pin_s3_r[0];
  assign scl_fall = ~pin_s2_r[0] & pin_s3_r[0];
  assign bus_start = pin_s2_r[0] & pin_s3_r[0] & pin_s3_r[1] & ~pin_s2_r[1];
  assign bus_stop = pin_s2_r[0] & pin_s3_r[0] & ~pin_s3_r[1] & pin_s2_r[1];
  // Bus slave state
  lsa_bus_st_t bus_st_r, bus_st_nxt;
  logic [3:0] bit_cnt_r, bit_cnt_nxt;
  logic [7:0] shift_r, shift_nxt, tx_r, tx_nxt, ptr_r, ptr_nxt, msb_hold_r, msb_hold_nxt;
  logic rw_r, rw_nxt, oe_r, oe_nxt, nack_r, nack_nxt;
  logic [1:0] mode_r, mode_nxt;
  logic [8:0] rdy_cnt_r, rdy_cnt_nxt;
  logic [15:0] result_r, result_nxt;
  logic active;
  assign active = (mode_r == MODE_ACTIVE);
  // Register pointer must name a reachable register; idle hides all but mode
  function automatic logic reg_ok(input logic [7:0] a, input logic act);
    reg_ok = (a == REG_MODE) || (act && (a == REG_PART || a == REG_MFR || a == REG_LSB || a == REG_MSB));
  endfunction
  // Block reads cycle through the map
  function automatic logic [7:0] ptr_next(input logic [7:0] a);
    unique case (a)
      REG_MODE: ptr_next = REG_PART;
      REG_PART: ptr_next = REG_MFR;
      REG_MFR: ptr_next = REG_LSB;
      REG_LSB: ptr_next = REG_MSB;
      default: ptr_next = REG_MODE;
    endcase
  endfunction
  // Bus next-state: bits sampled on SCL rise, SDA changed on SCL fall
  always_comb begin
    bus_st_nxt = bus_st_r;
    bit_cnt_nxt = bit_cnt_r;
    shift_nxt = shift_r;
    tx_nxt = tx_r;
    ptr_nxt = ptr_r;
    msb_hold_nxt = msb_hold_r;
    rw_nxt = rw_r;
    oe_nxt = oe_r;
    nack_nxt = nack_r;
    mode_nxt = mode_r;
    rdy_cnt_nxt = rdy_cnt_r;
    if (rdy_cnt_r != BUS_READY_CYC[8:0]) begin
      rdy_cnt_nxt = rdy_cnt_r + 9'h001;
    end else if (bus_start) begin
      bus_st_nxt = BUS_ADDR; // Also covers repeated start
      bit_cnt_nxt = 4'h0;
      oe_nxt = 1'b0;
    end else if (bus_stop) begin
      bus_st_nxt = BUS_IDLE;
      oe_nxt = 1'b0;
    end else if (scl_rise) begin
      if (bus_st_r == BUS_RACK) begin
        nack_nxt = pin_s2_r[1];
      end else if (bus_st_r != BUS_IDLE) begin
        shift_nxt = {shift_r[6:0], pin_s2_r[1]};
        bit_cnt_nxt = bit_cnt_r + 4'h1;
      end
    end else if (scl_fall) begin
      unique case (bus_st_r)
        BUS_IDLE: oe_nxt = 1'b0;
        BUS_ADDR: begin
          if (bit_cnt_r == 4'h8) begin
            if (shift_r[7:1] == DEV_ADDR) begin
              rw_nxt = shift_r[0];
              oe_nxt = 1'b1;
              bus_st_nxt = BUS_ADDR_ACK;
            end else begin
              bus_st_nxt = BUS_IDLE;
            end
          end
        end
        BUS_ADDR_ACK, BUS_RACK: begin
          bit_cnt_nxt = 4'h0;
          if (bus_st_r == BUS_ADDR_ACK && !rw_r) begin
            oe_nxt = 1'b0;
            bus_st_nxt = BUS_REG;
          end else if (bus_st_r == BUS_RACK && nack_r) begin
            oe_nxt = 1'b0;
            bus_st_nxt = BUS_IDLE;
          end else begin
            // Load the byte for the current pointer
            unique case (ptr_r)
              REG_MODE: tx_nxt = {6'h00, mode_r};
              REG_PART: tx_nxt = active ? ID_PART : 8'h00;
              REG_MFR: tx_nxt = active ? ID_MFR : 8'h00;
              REG_LSB: begin
                tx_nxt = active ? result_r[7:0] : 8'h00;
                msb_hold_nxt = result_r[15:8];
              end
              default: tx_nxt = active ? msb_hold_r : 8'h00;
            endcase
            oe_nxt = ~tx_nxt[7];
            bus_st_nxt = BUS_RDATA;
          end
        end
        BUS_REG: begin
          if (bit_cnt_r == 4'h8) begin
            if (reg_ok(shift_r, active)) begin
              ptr_nxt = shift_r;
              oe_nxt = 1'b1;
              bus_st_nxt = BUS_REG_ACK;
            end else begin
              bus_st_nxt = BUS_IDLE; // Unreachable register (unknown, or hidden while idle): no acknowledge
            end
          end
        end
        BUS_REG_ACK, BUS_WDATA_ACK: begin
          oe_nxt = 1'b0;
          bit_cnt_nxt = 4'h0;
          bus_st_nxt = BUS_WDATA;
        end
        BUS_WDATA: begin
          if (bit_cnt_r == 4'h8) begin
            if (ptr_r == REG_MODE) begin
              mode_nxt = shift_r[1:0];
              oe_nxt = 1'b1;
              bus_st_nxt = BUS_WDATA_ACK;
            end else begin
              bus_st_nxt = BUS_IDLE; // Read-only target
            end
          end
        end
        BUS_RDATA: begin
          if (bit_cnt_r == 4'h8) begin
            oe_nxt = 1'b0;
            ptr_nxt = ptr_next(ptr_r);
            bus_st_nxt = BUS_RACK;
          end else begin
            oe_nxt = ~tx_r[3'h7 - bit_cnt_r[2:0]];
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      bus_st_r <= BUS_IDLE;
      bit_cnt_r <= 4'h0;
      shift_r <= 8'h00;
      tx_r <= 8'h00;
      ptr_r <= REG_MODE;
      msb_hold_r <= 8'h00;
      rw_r <= 1'b0;
      oe_r <= 1'b0;
      nack_r <= 1'b0;
      mode_r <= MODE_RST;
      rdy_cnt_r <= 9'h000;
    end else if (i_ce) begin
      bus_st_r <= bus_st_nxt;
      bit_cnt_r <= bit_cnt_nxt;
      shift_r <= shift_nxt;
      tx_r <= tx_nxt;
      ptr_r <= ptr_nxt;
      msb_hold_r <= msb_hold_nxt;
      rw_r <= rw_nxt;
      oe_r <= oe_nxt;
      nack_r <= nack_nxt;
      mode_r <= mode_nxt;
      rdy_cnt_r <= rdy_cnt_nxt;
    end
  end

  // Measurement sequencer and sliding average over a 32-entry window
  lsa_seq_st_t seq_st_r, seq_st_nxt;
  logic [15:0] win_mem [AVG_MAX];
  logic [4:0] wr_idx_r, wr_idx_nxt;
  logic [5:0] n_r, n_nxt;
  logic [20:0] sum_r, sum_nxt;
  logic [31:0] smp_cnt_r, smp_cnt_nxt, ref_cnt_r, ref_cnt_nxt;
  logic conv_r, conv_nxt, active_d_r;
  logic [15:0] oldest;
  // Entries beyond the filled count are treated as zero, so no clearing pass is needed
  assign oldest = (n_r == AVG_MAX[5:0]) ? win_mem[wr_idx_r] : 16'h0000;

  always_comb begin
    seq_st_nxt = seq_st_r;
    wr_idx_nxt = wr_idx_r;
    n_nxt = n_r;
    sum_nxt = sum_r;
    smp_cnt_nxt = smp_cnt_r;
    ref_cnt_nxt = ref_cnt_r;
    conv_nxt = 1'b0;
    result_nxt = result_r;
    if (!active) begin
      seq_st_nxt = SEQ_OFF;
    end else if (!active_d_r || seq_st_r == SEQ_OFF) begin
      // Fresh activation drops old samples
      seq_st_nxt = SEQ_START;
      wr_idx_nxt = 5'h00;
      n_nxt = 6'h00;
      sum_nxt = 21'h000000;
      smp_cnt_nxt = 32'h0;
      conv_nxt = 1'b1;
    end else begin
      // Free-running sample period; conversions keep going in steady state
      conv_nxt = (smp_cnt_r == 32'(SAMPLE_CYCLES - 1));
      smp_cnt_nxt = conv_nxt ? 32'h0 : smp_cnt_r + 32'h1;
      if (i_conv.valid) begin
        sum_nxt = sum_r + {5'h00, i_conv.lux} - {5'h00, oldest};
        wr_idx_nxt = wr_idx_r + 5'h01;
        if (n_r != AVG_MAX[5:0]) begin
          n_nxt = n_r + 6'h01;
        end
      end
      if (seq_st_r == SEQ_START && i_conv.valid) begin
        // Start-up stages, one result write each
        if (n_nxt == 6'h01) begin
          result_nxt = i_conv.lux;
        end else if (n_nxt == STAGE_8[5:0]) begin
          result_nxt = sum_nxt[18:3];
        end else if (n_nxt == STAGE_16[5:0]) begin
          result_nxt = sum_nxt[19:4];
        end else if (n_nxt == AVG_MAX[5:0]) begin
          result_nxt = sum_nxt[20:5];
          seq_st_nxt = SEQ_STEADY;
          ref_cnt_nxt = 32'h0;
        end
      end else if (seq_st_r == SEQ_STEADY) begin
        if (ref_cnt_r == 32'(REFRESH_CYCLES - 1)) begin
          ref_cnt_nxt = 32'h0;
          result_nxt = sum_r[20:5];
        end else begin
          ref_cnt_nxt = ref_cnt_r + 32'h1;
        end
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      seq_st_r <= SEQ_OFF;
      wr_idx_r <= 5'h00;
      n_r <= 6'h00;
      sum_r <= 21'h000000;
      smp_cnt_r <= 32'h0;
      ref_cnt_r <= 32'h0;
      conv_r <= 1'b0;
      active_d_r <= 1'b0;
      result_r <= RESULT_RST;
    end else if (i_ce) begin
      seq_st_r <= seq_st_nxt;
      wr_idx_r <= wr_idx_nxt;
      n_r <= n_nxt;
      sum_r <= sum_nxt;
      smp_cnt_r <= smp_cnt_nxt;
      ref_cnt_r <= ref_cnt_nxt;
      conv_r <= conv_nxt;
      active_d_r <= active;
      result_r <= result_nxt;
    end
  end

  // Sample window storage, no reset needed
  always_ff @(posedge i_clk_sys) begin
    if (i_ce && active && active_d_r && seq_st_r != SEQ_OFF && i_conv.valid) begin
      win_mem[wr_idx_r] <= i_conv.lux;
    end
  end

  assign o_sda_out = 1'b0; // Open drain: only ever pulls low
  assign o_sda_oe = oe_r;
  assign o_conv_start = conv_r;
  assign o_result = result_r;
  assign o_active = active_d_r;
endmodule

//--- lsa_pkg.sv
// How it works
// - Published value averages the most recent conversions: 1, 8, 16 or 32 of them.
// - First 32-sample average appears after the 32nd conversion, well before 250 ms.
// - Reads before the full average return the latest intermediate result.
// - The first conversion is triggered at activation; its result is published directly.
// - First update follows the first conversion, inside 5.7 ms when the converter keeps pace.
// - Average of 8 published after the 8th conversion, of 16 after the 16th.
// - In steady state a fresh 32-sample average is published every 500 ms.
// - Single, 8 and 16 sample stages exist only in the start-up sequence.
// - Converter counts pass through unscaled: one count per lux.
// - Serial interface ignores the bus until 40 us after reset.
// - Open-drain pins, no clock stretching, address match before any drive.
// - Start, stop, acknowledge and bit timing follow the standard two-wire protocol.
// - Idle after reset, no conversions; only the mode register is reachable.
// - Mode bits 1:0 = 11 activates, 00 returns to low-power idle.
// - Reading the low result byte holds the high byte for the next read.
package lsa_pkg;
  localparam int CLK_MHZ = 10;
  // Timing, in own units
  localparam int T_BUS_READY_US = 40;
  localparam int T_SAMPLE_US = 5700;
  localparam int T_REFRESH_MS = 500;
  localparam int BUS_READY_CYC = T_BUS_READY_US * CLK_MHZ;
  localparam int SAMPLE_CYC = T_SAMPLE_US * CLK_MHZ;
  localparam int REFRESH_CYC = T_REFRESH_MS * 1000 * CLK_MHZ;
  // Averaging depth and start-up stages
  localparam int AVG_MAX = 32;
  localparam int STAGE_8 = 8;
  localparam int STAGE_16 = 16;
  // Bus address and register offsets
  localparam logic [6:0] DEV_ADDR = 7'h29;
  localparam logic [7:0] REG_MODE = 8'h80;
  localparam logic [7:0] REG_PART = 8'h8a;
  localparam logic [7:0] REG_MFR = 8'h8b;
  localparam logic [7:0] REG_LSB = 8'h8c;
  localparam logic [7:0] REG_MSB = 8'h8d;
  localparam logic [1:0] MODE_IDLE = 2'h0;
  localparam logic [1:0] MODE_ACTIVE = 2'h3;
  localparam logic [1:0] MODE_RST = 2'h0;
  localparam logic [15:0] RESULT_RST = 16'h0000;
  // Identity bytes: values are arbitrary
  localparam logic [7:0] ID_PART_DEF = 8'h5a;
  localparam logic [7:0] ID_MFR_DEF = 8'h3c;

  typedef enum {BUS_IDLE, BUS_ADDR, BUS_ADDR_ACK, BUS_REG, BUS_REG_ACK, BUS_WDATA, BUS_WDATA_ACK,
    BUS_RDATA, BUS_RACK} lsa_bus_st_t;
  typedef enum {SEQ_OFF, SEQ_START, SEQ_STEADY} lsa_seq_st_t;

  typedef struct packed {
    logic valid;
    logic [15:0] lux;
  } lsa_conv_t;
endpackage

//--- lsa_top_sva.sv
`timescale 1ns/1ps
module lsa_top_sva import lsa_pkg::*; #(
  parameter int SAMPLE_CYCLES = SAMPLE_CYC,
  parameter int REFRESH_CYCLES = REFRESH_CYC
) (
  input wire logic i_clk_sys,
  input wire logic i_srst,
  input wire logic i_ce,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic o_sda_out,
  input wire logic o_sda_oe,
  input wire logic o_conv_start,
  input wire lsa_conv_t i_conv,
  input wire logic [15:0] o_result,
  input wire logic o_active
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_srst);
  logic [5:0] vc_r, vc_nxt;
  logic [20:0] sum_r, sum_nxt, nsum;
  logic [15:0] avg, res_r;
  logic [9:0] up_r, up_nxt;
  int chg_r, chg_nxt;
  logic take;
  // Reference averager; restarts whenever the sequencer drops
  always_comb begin
    take = i_conv.valid && o_active && vc_r < 6'h20;
    nsum = sum_r + 21'(i_conv.lux);
    avg = vc_r == 6'h07 ? 16'(nsum >> 3) : vc_r == 6'h0f ? 16'(nsum >> 4) : 16'(nsum >> 5);
    vc_nxt = !o_active ? 6'h00 : take ? vc_r + 6'h01 : vc_r;
    sum_nxt = !o_active ? 21'h000000 : take ? nsum : sum_r;
    up_nxt = up_r == 10'h3ff ? up_r : up_r + 10'h001;
    chg_nxt = o_result != res_r ? 0 : chg_r + 1;
  end
  // Registers only; the age counter saturates so it never wraps
  always_ff @(posedge i_clk_sys) begin
    vc_r <= i_srst ? 6'h00 : vc_nxt;
    sum_r <= i_srst ? 21'h000000 : sum_nxt;
    up_r <= i_srst ? 10'h000 : up_nxt;
    chg_r <= i_srst ? 0 : chg_nxt;
    res_r <= o_result;
  end
  sequence s_quiet8;
    !o_conv_start [*8];
  endsequence
  AST_RST_VALUES: assert property ($fell(i_srst) |-> !o_sda_oe && !o_active && o_result == RESULT_RST)
    else $error("outputs not at reset values");
  AST_SDA_ZERO: assert property (o_sda_out == 1'b0)
    else $error("sda drive value not low");
  AST_BUS_QUIET: assert property (up_r < 10'h190 |-> !o_sda_oe)
    else $error("sda driven before bus ready");
  AST_SDA_EDGE: assert property ($changed(o_sda_oe) |-> !i_scl)
    else $error("sda moved while scl high");
  AST_CONV_GAP: assert property (o_conv_start |=> s_quiet8)
    else $error("conversion starts too close");
  AST_FIRST: assert property (take && vc_r == 6'h00 |=> o_result == $past(i_conv.lux))
    else $error("first sample not published");
  AST_STAGE_AVG: assert property (take && vc_r inside {6'h07, 6'h0f, 6'h1f} |=> o_result == $past(avg))
    else $error("stage average wrong");
  AST_STAGE_HOLD: assert property (o_active && vc_r < 6'h20 && !(take && vc_r inside {6'h00, 6'h07, 6'h0f, 6'h1f})
    |=> $stable(o_result))
    else $error("result moved between stages");
  AST_STEADY: assert property (vc_r == 6'h20 && o_result != res_r |-> chg_r >= REFRESH_CYCLES - 2)
    else $error("steady refresh too early");
endmodule
bind lsa_top lsa_top_sva #(.SAMPLE_CYCLES(SAMPLE_CYCLES), .REFRESH_CYCLES(REFRESH_CYCLES)) i_sva (
  .i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_ce(i_ce), .i_scl(i_scl), .i_sda(i_sda), .o_sda_out(o_sda_out),
  .o_sda_oe(o_sda_oe), .o_conv_start(o_conv_start), .i_conv(i_conv), .o_result(o_result), .o_active(o_active));

//--- lsa_host_model.sv
`timescale 1ns/1ps
module lsa_host_model import lsa_pkg::*; (
  input wire logic i_clk,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda_low,
  output logic o_evt,
  output logic [7:0] o_val
);
  // Bus released at time zero
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
    o_evt = 1'b0;
    o_val = 8'h00;
  end
  task automatic wt(input int k);
    repeat (k) @(negedge i_clk);
  endtask
  // Data moves only with the clock low; cnd adds a start or stop edge
  task automatic clk_bit(input logic b, input logic cnd, output logic r);
    o_scl = 1'b0;
    wt(6);
    o_sda_low = !b;
    wt(2);
    o_scl = 1'b1;
    wt(4);
    r = i_sda;
    wt(4);
    if (cnd) begin
      o_sda_low = b;
      wt(8);
    end
  endtask
  task automatic note(input logic [7:0] v);
    o_val = v;
    o_evt = 1'b1;
    wt(1);
    o_evt = 1'b0;
  endtask
  // One byte plus its acknowledge slot; reports data on reads, the ack on writes
  task automatic xfer(input logic [7:0] d, input logic last, input logic rd, output logic ack);
    logic [7:0] q;
    logic r;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(d[i], 1'b0, r);
      q[i] = r;
    end
    clk_bit(last, 1'b0, r);
    ack = !r;
    note(rd ? q : {7'h00, !r});
  endtask
  // Write of one byte, or combined read of two; a refused register ends a read, but a write still sends its data byte
  task automatic xact(input logic [7:0] r, input logic [7:0] d, input logic rd);
    logic k;
    clk_bit(1'b1, 1'b1, k);
    xfer({DEV_ADDR, 1'b0}, 1'b1, 1'b0, k);
    xfer(r, 1'b1, 1'b0, k);
    if (!rd) begin
      xfer(d, 1'b1, 1'b0, k);
    end else if (k) begin
      clk_bit(1'b1, 1'b1, k);
      xfer({DEV_ADDR, 1'b1}, 1'b1, 1'b0, k);
      xfer(8'hff, 1'b0, 1'b1, k);
      xfer(8'hff, 1'b1, 1'b1, k);
    end
    clk_bit(1'b0, 1'b1, k);
  endtask
endmodule

//--- test_light_sample_averager.sv
`timescale 1ns/1ps
module test_light_sample_averager import lsa_pkg::*; ();
  logic i_clk_sys, i_srst, scl, sda, sda_low, sda_oe, sda_out, conv_start, active, h_evt, t_evt, rnd;
  logic [7:0] h_val;
  logic [15:0] result, lux_now, t_val, a, b;
  logic [15:0] exp_q[$];
  logic [2:0] cs_d;
  lsa_conv_t conv;
  int fails, compares, n;
  lsa_top #(.SAMPLE_CYCLES(20), .REFRESH_CYCLES(200)) i_dut (.i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_ce(1'b1),
    .i_scl(scl), .i_sda(sda), .o_sda_out(sda_out), .o_sda_oe(sda_oe), .o_conv_start(conv_start), .i_conv(conv),
    .o_result(result), .o_active(active));
  lsa_host_model i_host (.i_clk(i_clk_sys), .i_sda(sda), .o_scl(scl), .o_sda_low(sda_low), .o_evt(h_evt),
    .o_val(h_val));
  // Open-drain data line with pull-up
  assign sda = (sda_low || (sda_oe && !sda_out)) ? 1'b0 : 1'b1;
  initial begin
    i_clk_sys = 1'b0;
    forever #50 i_clk_sys = ~i_clk_sys;
  end
  // Converter answers four cycles after each start; lux lines toggle when not valid
  always @(negedge i_clk_sys) begin
    cs_d <= {cs_d[1:0], conv_start};
    conv.valid <= cs_d[2];
    conv.lux <= cs_d[2] ? (rnd ? 16'($urandom_range(65000, 3)) : lux_now) : ~conv.lux;
  end
  task automatic complete_run();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic check(input logic [15:0] got);
    logic [15:0] want;
    compares++;
    want = exp_q.size() > 0 ? exp_q.pop_front() : 16'hxxxx;
    if (got !== want) begin
      fails++;
      $display("mismatch at %0t: got %h want %h", $time, got, want);
    end
  endtask
  // Oldest note is taken off whenever a result appears
  always @(posedge i_clk_sys) begin
    if (h_evt === 1'b1) check({8'h00, h_val});
    if (t_evt === 1'b1) check(t_val);
  end
  task automatic look(input logic [15:0] want, input logic [15:0] got);
    exp_q.push_back(want);
    t_val = got;
    t_evt = 1'b1;
    @(negedge i_clk_sys);
    t_evt = 1'b0;
  endtask
  task automatic acks(input int k);
    repeat (k) exp_q.push_back(16'h0001);
  endtask
  task automatic wr(input logic [7:0] d);
    acks(3);
    i_host.xact(REG_MODE, d, 1'b0);
  endtask
  task automatic rd_pair(input logic [15:0] v);
    acks(3);
    exp_q.push_back({8'h00, v[7:0]});
    exp_q.push_back({8'h00, v[15:8]});
    i_host.xact(REG_LSB, 8'h00, 1'b1);
  endtask
  initial begin
    repeat (20000) @(posedge i_clk_sys);
    fails++;
    $display("mismatch at %0t: watchdog expired", $time);
    complete_run();
  end
  initial begin
    i_srst = 1'b1;
    conv = '0;
    cs_d = 3'h0;
    rnd = 1'b0;
    t_evt = 1'b0;
    t_val = 16'h0000;
    lux_now = 16'h0000;
    void'($urandom(84953));
    repeat (20) @(negedge i_clk_sys);
    i_srst = 1'b0;
    repeat (420) @(negedge i_clk_sys);
    acks(1);
    exp_q.push_back(16'h0000);
    i_host.xact(REG_LSB, 8'h00, 1'b1);
    look(RESULT_RST, result);
    $display("test idle done");
    a = 16'($urandom_range(65000, 3));
    lux_now = a;
    wr(8'h03);
    n = 0;
    while (result === 16'h0000 && n < 15000) begin
      @(negedge i_clk_sys);
      n++;
    end
    look(a, result);
    rd_pair(a);
    $display("test start-up done");
    repeat (900) @(negedge i_clk_sys);
    b = 16'($urandom_range(65000, 3));
    lux_now = b;
    repeat (1100) @(negedge i_clk_sys);
    look(b, result);
    rd_pair(b);
    $display("test steady done");
    wr(8'h00);
    n = 0;
    repeat (100) begin
      @(negedge i_clk_sys);
      n += int'(conv_start === 1'b1);
    end
    look(16'h0000, 16'(n));
    rnd = 1'b1;
    wr(8'h03);
    repeat (900) @(negedge i_clk_sys);
    look(16'h0001, {15'h0000, active});
    $display("test restart done");
    complete_run();
  end
endmodule
